// file: common/pwr_seq_pkg.sv
package pwr_seq_pkg;
   // System clock and real-time clock rates
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned RTC_HZ = 32768;
   localparam int unsigned TICK_CYC = CLK_HZ / RTC_HZ;
   // Toggle qualification time, a least time so it rounds up
   localparam int unsigned FILT_US = 100;
   localparam int unsigned FILT_CYC = (FILT_US * (CLK_HZ / 1000) + 999) / 1000;
   // Real-time clock start-up and shutdown window, in milliseconds
   localparam int unsigned RTC_START_MS = 300;
   localparam int unsigned SHUT_MIN_MS = 10;
   localparam int unsigned SHUT_MAX_MS = 900;
   localparam int unsigned RTC_START_CYC = RTC_START_MS * (CLK_HZ / 1000);
   localparam int unsigned SHUT_MIN_CYC = SHUT_MIN_MS * (CLK_HZ / 1000);
   localparam int unsigned SHUT_MAX_CYC = SHUT_MAX_MS * (CLK_HZ / 1000);
   localparam int unsigned LONG_W = 24;
   // Sequence timing in real-time-clock ticks
   localparam int unsigned TICK_W = 12;
   localparam logic [TICK_W-1:0] READY_PULSE_TICKS = 12'h00a;
   localparam logic [TICK_W-1:0] WAKE_TICKS = 12'h006;
   localparam logic [TICK_W-1:0] BOOT_TICKS = 12'h852;
   // Host port selection and serial defaults
   typedef enum logic [1:0] {PORT_UART, PORT_SPI, PORT_I2C} host_port_t;
   localparam int unsigned UART_BAUD = 4800;
   localparam logic [15:0] BAUD_DEFAULT = 16'(CLK_HZ / UART_BAUD);
   // Sequencer states
   typedef enum logic [2:0] {
      ST_RTC_START, ST_READY_PULSE, ST_READY, ST_STARTING,
      ST_RUNNING, ST_SHUTDOWN, ST_HIBERNATE
   } seq_state_t;
endpackage

// file: common/toggle_if.sv
`timescale 1ns/100ps
interface toggle_if;
   logic event_set; // One-cycle pulse when the detector sets
   logic level;     // Qualified detector state
   modport det (output event_set, output level);
   modport seq (input event_set, input level);
endinterface

// file: hw/power_sequencer.sv
`timescale 1ns/100ps
// Notes on behaviour
// - At power-up sit in clock start-up until the clock runs, then become ready.
// - Internal power-on reset clears everything; no host reset needed.
// - Ready, ready pulse or hibernate: a valid toggle pulse begins start-up.
// - Toggle detector sets after a rising edge and 100 us of high.
// - Toggle detector clears after 100 us of low.
// - When ready, emit a 10-tick high pulse on the power-state output.
// - Clock start-up takes nominally 300 ms before the ready pulse.
// - Power-state output goes high 6 ticks after the toggle pulse.
// - Processor boots 2130 ticks after the toggle pulse.
// - Output looped to toggle input makes the block start itself.
// - Power-state output high signals start-up has begun, not completed.
// - First message after start-up is the ok-to-send notice.
// - UART port sends sentences at 4800 bit/s, autonomously after start.
// - I2C multi-master sends only while the bus is granted.
// - Toggle pulse or shutdown command leaves full power for hibernate.
// - Shutdown stays in full power 10 to 900 ms until TX FIFO drains.
// - Shutdown notice is the last message before hibernate.
// - Commanded settings are lost and defaults return after reset.
// - Power-state output low in low-power states, high in full power.
module power_sequencer
   import pwr_seq_pkg::*;
#(
   parameter int unsigned START_CYC = RTC_START_CYC,
   parameter int unsigned MIN_SHUT_CYC = SHUT_MIN_CYC,
   parameter int unsigned MAX_SHUT_CYC = SHUT_MAX_CYC,
   parameter int unsigned TICK_DIV = TICK_CYC,
   parameter int unsigned FILT_LEN = FILT_CYC
) (
   // Clock and internal power-on reset
   input wire logic clk,
   input wire logic rst_n,
   // Host control pins
   input wire logic toggle_in,
   output logic power_state,
   // Port straps, sampled once after reset
   input wire logic [1:0] port_strap,
   // Firmware side: commands and transmit path
   input wire logic shutdown_cmd,
   input wire logic protocol_change_cmd,
   input wire logic [1:0] new_port,
   input wire logic [15:0] new_baud_div,
   input wire logic tx_fifo_empty,
   input wire logic i2c_bus_granted,
   // Processor and message controls
   output logic cpu_boot,
   output logic ok_to_send_msg,
   output logic shutdown_notice_msg,
   output logic msg_enable,
   output logic [1:0] host_port,
   output logic [15:0] uart_baud_div,
   output logic ready
);
   seq_state_t state;
   seq_state_t next_state;
   logic tick;
   logic [TICK_W-1:0] tick_cnt;
   logic [LONG_W-1:0] long_cnt;
   logic strap_taken;
   toggle_if tgl();

   rtc_tick #(.DIV(TICK_DIV)) u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   toggle_qualifier #(.FILT(FILT_LEN)) u_qual (
      .clk(clk),
      .rst_n(rst_n),
      .toggle_raw(toggle_in),
      .q(tgl.det)
   );

   // Decode of counters and requests
   wire tick_last_ready = tick && (tick_cnt == READY_PULSE_TICKS - 12'h001);
   wire tick_wake = tick && (tick_cnt == WAKE_TICKS - 12'h001);
   wire tick_boot = tick && (tick_cnt == BOOT_TICKS - 12'h001);
   wire rtc_up = (long_cnt == LONG_W'(START_CYC - 1));
   wire shut_min = (long_cnt >= LONG_W'(MIN_SHUT_CYC - 1));
   wire shut_max = (long_cnt == LONG_W'(MAX_SHUT_CYC - 1));
   // Each window saturates at its own end; a shared stop would freeze
   // the shutdown count at the start-up limit and lose the timeout
   wire long_hold = (state == ST_RTC_START) ? rtc_up : shut_max;
   wire can_start = (state == ST_READY_PULSE) || (state == ST_READY) ||
                    (state == ST_HIBERNATE);
   wire start_req = can_start && tgl.event_set;
   wire stop_req = (state == ST_RUNNING) &&
                   (tgl.event_set || shutdown_cmd);
   // Drain before leaving; the upper bound keeps a stuck FIFO from
   // holding full power forever
   wire shut_done = (shut_min && tx_fifo_empty) || shut_max;
   wire port_i2c = (host_port == 2'(PORT_I2C));
   wire next_msg_en = (next_state == ST_RUNNING) &&
                      (!port_i2c || i2c_bus_granted);

   // Next-state choice
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RTC_START: if (rtc_up) next_state = ST_READY_PULSE;
         ST_READY_PULSE: begin
            if (start_req) next_state = ST_STARTING;
            else if (tick_last_ready) next_state = ST_READY;
         end
         ST_READY: if (start_req) next_state = ST_STARTING;
         ST_STARTING: if (tick_boot) next_state = ST_RUNNING;
         ST_RUNNING: if (stop_req) next_state = ST_SHUTDOWN;
         ST_SHUTDOWN: if (shut_done) next_state = ST_HIBERNATE;
         ST_HIBERNATE: if (start_req) next_state = ST_STARTING;
      endcase
   end

   // State register; reset lands in the clock start-up state, ST_RTC_START
   always_ff @(posedge clk) begin
      if (!rst_n) state <= ST_RTC_START;
      else state <= next_state;
   end

   // Tick counter restarts at every state change
   always_ff @(posedge clk) begin
      if (!rst_n || next_state != state) tick_cnt <= '0;
      else if (tick) tick_cnt <= tick_cnt + 12'h001;
   end

   // Long counter times clock start-up and the shutdown window
   always_ff @(posedge clk) begin
      if (!rst_n || next_state != state) long_cnt <= '0;
      else if (!long_hold) long_cnt <= long_cnt + 24'h000001;
   end

   // Power-state pin: ready pulse, rise after start, low when asleep
   always_ff @(posedge clk) begin
      if (!rst_n) power_state <= 1'b0;
      else if (next_state == ST_READY_PULSE && state == ST_RTC_START)
         power_state <= 1'b1;
      else if (start_req || next_state == ST_HIBERNATE)
         power_state <= 1'b0;
      else if (state == ST_READY_PULSE && tick_last_ready)
         power_state <= 1'b0;
      else if (state == ST_STARTING && tick_wake)
         power_state <= 1'b1;
   end

   // Processor boot and message strobes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cpu_boot <= 1'b0;
         ok_to_send_msg <= 1'b0;
         shutdown_notice_msg <= 1'b0;
         msg_enable <= 1'b0;
         ready <= 1'b0;
      end else begin
         if (state == ST_STARTING && tick_boot) cpu_boot <= 1'b1;
         else if (next_state == ST_HIBERNATE) cpu_boot <= 1'b0;
         ok_to_send_msg <= (state == ST_STARTING) && tick_boot;
         // Queued behind pending traffic so it is the last to leave
         shutdown_notice_msg <= stop_req;
         msg_enable <= next_msg_en;
         ready <= (next_state == ST_READY) || (next_state == ST_READY_PULSE);
      end
   end

   // Volatile settings: straps and defaults return after every reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strap_taken <= 1'b0;
         host_port <= 2'(PORT_UART);
         uart_baud_div <= BAUD_DEFAULT;
      end else begin
         strap_taken <= 1'b1;
         if (!strap_taken) host_port <= port_strap;
         else if (protocol_change_cmd && state == ST_RUNNING) begin
            host_port <= new_port;
            uart_baud_div <= new_baud_div;
         end
      end
   end

   a_ready_pulse_len: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(power_state) && state == ST_READY_PULSE |->
      power_state [*8])
      else $error("ready pulse too short");
   a_wake_at_six: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_STARTING && tick && tick_cnt == WAKE_TICKS - 12'h001 |=>
      power_state)
      else $error("power-state not high six ticks after start");
   a_boot_at_count: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(cpu_boot) |-> $past(tick_cnt) == BOOT_TICKS - 12'h001 &&
      ok_to_send_msg)
      else $error("boot not at tick 2130 or without ok-to-send");
   a_first_msg_ok: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(msg_enable) && $past(state) == ST_STARTING |->
      ok_to_send_msg && cpu_boot)
      else $error("messages began before ok-to-send");
   a_low_power_low: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_READY || state == ST_HIBERNATE |-> !power_state)
      else $error("power-state high in a low-power state");
   a_full_power_high: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_RUNNING |-> power_state && cpu_boot)
      else $error("power-state low in full power");
   a_start_on_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      tgl.event_set && state == ST_HIBERNATE |=>
      state == ST_STARTING)
      else $error("toggle pulse did not start the block");
   a_stop_on_cmd: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_RUNNING && shutdown_cmd |=> state == ST_SHUTDOWN &&
      shutdown_notice_msg)
      else $error("shutdown command not taken");
   a_drain_first: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_SHUTDOWN && !tx_fifo_empty && !shut_max |=>
      state == ST_SHUTDOWN && power_state)
      else $error("left full power with data still queued");
   a_defaults_back: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> uart_baud_div == BAUD_DEFAULT &&
      state == ST_RTC_START)
      else $error("settings not restored by reset");
endmodule

// file: hw/rtc_tick.sv
`timescale 1ns/100ps
module rtc_tick
   import pwr_seq_pkg::*;
#(
   parameter int unsigned DIV = TICK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // One-cycle tick per real-time-clock period
   output logic tick
);
   logic [15:0] cnt;
   wire wrap = (cnt == 16'(DIV - 1));

   // Divide the system clock down to the real-time-clock rate
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         cnt <= wrap ? '0 : cnt + 16'h0001;
         tick <= wrap;
      end
   end

   a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
      tick |=> !tick [*8]) else $error("tick came too soon");
endmodule

// file: hw/toggle_qualifier.sv
`timescale 1ns/100ps
module toggle_qualifier
   import pwr_seq_pkg::*;
#(
   parameter int unsigned FILT = FILT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw toggle pin and qualified result
   input wire logic toggle_raw,
   toggle_if.det q
);
   logic meta;
   logic sync;
   logic armed;
   logic [15:0] run;
   wire differs = (sync != q.level);
   wire done = (run == 16'(FILT - 1));
   wire may_set = !q.level && armed;
   wire flip = differs && done && (q.level || may_set);

   // Two-stage synchroniser; only the second stage is looked at
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= 1'b0;
         sync <= 1'b0;
      end else begin
         meta <= toggle_raw;
         sync <= meta;
      end
   end

   // A high only counts once a low was seen; sync resets low, so a pin stuck
   // high at reset still arms it and is taken as a rising edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         armed <= 1'b0;
         run <= '0;
         q.level <= 1'b0;
         q.event_set <= 1'b0;
      end else begin
         if (!sync) armed <= 1'b1;
         else if (flip) armed <= 1'b0;
         run <= (differs && !done) ? run + 16'h0001 : '0;
         if (flip) q.level <= sync;
         q.event_set <= flip && !q.level;
      end
   end

   a_set_after_high: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(q.level) |-> $past(sync) && $past(run) == 16'(FILT - 1))
      else $error("detector set without a full high period");
   a_clear_after_low: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(q.level) |-> !$past(sync) && $past(run) == 16'(FILT - 1))
      else $error("detector cleared without a full low period");
   a_event_with_set: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(q.level) |-> q.event_set ##1 !q.event_set)
      else $error("set event missing or too long");
endmodule

// file: sim/gnss_module_power_start_sequencer_tb.sv
`timescale 1ns/100ps
module gnss_module_power_start_sequencer_tb;
   import pwr_seq_pkg::*;
   // Short counts and a fast tick keep the run brief; the filter stays
   // well under the ready pulse so loop-back still qualifies
   localparam int unsigned ST = 50;
   localparam int unsigned MX = 200;
   localparam int T = 20;
   localparam int FL = 100;
   typedef struct {logic [1:0] port; logic [15:0] baud;} row_t;
   logic clk, rst_n, toggle_in, power_state, shutdown_cmd, ready, cpu_boot;
   logic protocol_change_cmd, tx_fifo_empty, i2c_bus_granted, msg_enable;
   logic ok_to_send_msg, shutdown_notice_msg, loop_back, pulse_req;
   logic [1:0] port_strap, new_port, host_port;
   logic [15:0] new_baud_div, uart_baud_div, pulse_cyc;
   int n_fail, checks_done, cyc, t0, d;
   row_t rows [3];

   power_sequencer #(.START_CYC(ST), .MIN_SHUT_CYC(20), .MAX_SHUT_CYC(MX),
      .TICK_DIV(T), .FILT_LEN(FL))
   u_dut (.clk(clk), .rst_n(rst_n), .toggle_in(toggle_in),
      .power_state(power_state), .port_strap(port_strap),
      .shutdown_cmd(shutdown_cmd), .protocol_change_cmd(protocol_change_cmd),
      .new_port(new_port), .new_baud_div(new_baud_div),
      .tx_fifo_empty(tx_fifo_empty), .i2c_bus_granted(i2c_bus_granted),
      .cpu_boot(cpu_boot), .ok_to_send_msg(ok_to_send_msg),
      .shutdown_notice_msg(shutdown_notice_msg), .msg_enable(msg_enable),
      .host_port(host_port), .uart_baud_div(uart_baud_div), .ready(ready));

   host_model u_host (.clk(clk), .loop_back(loop_back), .pulse_req(pulse_req),
      .pulse_cyc(pulse_cyc), .power_state(power_state), .toggle_in(toggle_in));

   // Clock and cycle count
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   task automatic chk(input string name, input logic [15:0] seen,
         input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict;
      if (n_fail == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Inputs always change one nanosecond after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Bounded wait on the state pin (w=0) or the boot flag (w=1)
   task automatic wait_sig(input int w, input logic lvl, input int lim);
      int k;
      k = 0;
      while ((w ? cpu_boot : power_state) !== lvl && k < lim) begin
         step(1);
         k++;
      end
      if (k >= lim) begin
         n_fail++;
         $display("[FAIL] wait %0d expected %h seen other", w, lvl);
         print_verdict();
      end
   endtask

   task automatic pulse(input logic [15:0] n);
      pulse_cyc = n;
      pulse_req = 1'b1;
      step(1);
      pulse_req = 1'b0;
   endtask

   initial begin
      clk = 1'b0; cyc = 0; n_fail = 0; checks_done = 0;
      rst_n = 1'b0; loop_back = 1'b0; pulse_req = 1'b0; pulse_cyc = 16'h0000;
      port_strap = 2'h2; shutdown_cmd = 1'b0; protocol_change_cmd = 1'b0;
      new_port = 2'h0; new_baud_div = 16'h0000; tx_fifo_empty = 1'b0;
      i2c_bus_granted = 1'b1;
      rows[0] = '{2'h1, 16'h0341};
      rows[1] = '{2'h0, 16'h00d0};
      rows[2] = '{2'h2, 16'h0823};
      step(16);
      chk("reset power_state", 16'(power_state), 16'h0000);
      chk("reset baud", uart_baud_div, BAUD_DEFAULT);
      rst_n = 1'b1;
      step(2);
      chk("strap port", 16'(host_port), 16'h0002);
      // Ready pulse arrives on its own after the clock start-up
      wait_sig(0, 1'b1, ST + 10);
      chk("ready in pulse", 16'(ready), 16'h0001);
      t0 = cyc;
      wait_sig(0, 1'b0, 11 * T);
      d = cyc - t0;
      chk("ready width", 16'(d >= 9 * T && d <= 10 * T + 2), 16'h0001);
      chk("ready held", 16'(ready), 16'h0001);
      // A pulse shorter than the qualify time is ignored
      pulse(16'd50);
      step(300);
      chk("short pulse", 16'(power_state), 16'h0000);
      t0 = cyc;
      pulse(16'd200);
      wait_sig(0, 1'b1, 7 * T + 200);
      d = cyc - t0;
      chk("wake delay", 16'(d >= FL + 5 * T && d <= FL + 10 + 6 * T),
         16'h0001);
      // Boot is fixed in ticks and takes most of the run
      wait_sig(1, 1'b1, 2131 * T + 200);
      d = cyc - t0;
      chk("boot delay", 16'(d >= FL + 2129 * T && d <= FL + 10 + 2130 * T),
         16'h0001);
      chk("ok to send", 16'(ok_to_send_msg), 16'h0001);
      chk("msg enable", 16'(msg_enable), 16'h0001);
      chk("full power", 16'(power_state), 16'h0001);
      step(1);
      chk("ok to send once", 16'(ok_to_send_msg), 16'h0000);
      i2c_bus_granted = 1'b0;
      step(2);
      chk("bus lost", 16'(msg_enable), 16'h0000);
      i2c_bus_granted = 1'b1;
      step(2);
      // Every port setting through the protocol change command; commands
      // come long after the state pin rose, as a port slave needs
      foreach (rows[i]) begin
         new_port = rows[i].port;
         new_baud_div = rows[i].baud;
         protocol_change_cmd = 1'b1;
         step(1);
         protocol_change_cmd = 1'b0;
         step(1);
         chk("new port", 16'(host_port), 16'(rows[i].port));
         chk("new baud", uart_baud_div, rows[i].baud);
      end
      // Shutdown holds full power while the transmit queue is busy
      shutdown_cmd = 1'b1;
      step(1);
      shutdown_cmd = 1'b0;
      chk("notice", 16'(shutdown_notice_msg), 16'h0001);
      chk("msg off", 16'(msg_enable), 16'h0000);
      step(MX / 2);
      chk("fifo busy", 16'({power_state, cpu_boot}), 16'h0003);
      tx_fifo_empty = 1'b1;
      wait_sig(0, 1'b0, 5);
      chk("hibernate", 16'(cpu_boot), 16'h0000);
      // From hibernate, pulse again until the state pin stays high
      for (int i = 0; i < 3 && power_state !== 1'b1; i++) begin
         pulse(16'd200);
         step(400);
      end
      chk("restart", 16'(power_state), 16'h0001);
      // Second reset drops commanded settings and retakes the strap
      rst_n = 1'b0;
      port_strap = 2'h0;
      loop_back = 1'b1;
      step(16);
      chk("reset baud again", uart_baud_div, BAUD_DEFAULT);
      rst_n = 1'b1;
      step(2);
      chk("strap again", 16'(host_port), 16'h0000);
      // Looped back, the ready pulse starts the block by itself
      wait_sig(0, 1'b1, ST + 10);
      step(600);
      chk("self start", 16'(power_state), 16'h0001);
      step(300);
      chk("self start held", 16'(power_state), 16'h0001);
      print_verdict();
   end
endmodule

// file: sim/host_model.sv
`timescale 1ns/100ps
// Host controller: pulses the toggle pin or loops the state pin back
module host_model (
   // Clock
   input wire logic clk,
   // Bench control
   input wire logic loop_back,
   input wire logic pulse_req,
   input wire logic [15:0] pulse_cyc,
   // Pins
   input wire logic power_state,
   output logic toggle_in
);
   logic drive = 1'b0;
   int unsigned left = 0;
   // Low-high-low pulse; the pin rests low as if pulled down
   always @(posedge clk) begin
      if (pulse_req) begin
         drive <= #1 1'b1;
         left <= {16'h0000, pulse_cyc};
      end else if (left > 1) begin
         left <= left - 1;
      end else begin
         drive <= #1 1'b0;
         left <= 0;
      end
   end
   // Loop-back wires the state pin straight onto the toggle pin
   assign toggle_in = loop_back ? power_state : drive;
endmodule
